// ===== bench/fcp_flash_model.sv
// behavioural boot-block flash answering the host controller pins
`timescale 1ns/1ps
module fcp_flash_model
   import fcp_pkg::*;
#(
   parameter bit BOOT_TOP = 1'b0, // boot block at top when set
   parameter int BUSY_NS = 1000, // engine run time
   parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'hA4 // arbitrary value
)
(
   input wire fcp_pkg::fcp_pins_t pins, // controller pins
   input wire logic vpp_ok, // program supply present
   output logic [15:0] dq // data pins seen by the controller
);
   logic [15:0] mem [16];
   logic [15:0] rv;
   logic [15:0] last;
   logic [5:3] err;
   logic [1:0] mode;
   logic [1:0] ps;
   logic eng;
   logic [3:0] blk;
   logic ok;
   logic rd;
   logic wr;
   // -----------------------------------------------
   // command decoder and engine
   // -----------------------------------------------
   initial
   begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {err, mode, ps, eng, last} = '0;
   end
   assign blk = pins.addr[19:16]; // one word stands for a whole block
   // boot block needs the unlock pin, the rest only supply
   assign ok = vpp_ok && (pins.boot_unlock || blk != (BOOT_TOP ? 4'hF : 4'h0));
   // writes latch when select and write enable stop overlapping; the controller
   // lifts both on one edge, so neither pin alone marks the end
   assign wr = !pins.ce_n && !pins.we_n;
   always @(negedge wr)
   begin
      if (pins.reset_powerdown_n && !eng)
      begin
         if (ps == 2'h1 || (ps == 2'h2 && pins.dq_out[7:0] == FCP_CMD_ERASE_CONFIRM))
         begin
            if (!vpp_ok) err[3] = 1'b1;
            if (!ok) err[(ps == 2'h1) ? 4 : 5] = 1'b1;
            else if (ps == 2'h2) mem[blk] = 16'hFFFF;
            else mem[blk] = mem[blk] & (pins.wide_n ? pins.dq_out : {8'hFF, pins.dq_out[7:0]});
            eng = 1'b1;
            mode = 2'h1;
            ps = 2'h0;
            fork
               #(BUSY_NS) eng = 1'b0;
            join_none
         end
         else
         begin
            ps = 2'h0;
            case (pins.dq_out[7:0])
               FCP_CMD_ERASE_SETUP: ps = 2'h2;
               FCP_CMD_WRITE_SETUP, FCP_CMD_WRITE_SETUP_ALT: ps = 2'h1;
               FCP_CMD_READ_STATUS: mode = 2'h1;
               FCP_CMD_IDENTIFY: mode = 2'h2;
               default: mode = 2'h0;
            endcase
         end
      end
   end
   // power-down forgets status and pending setups
   always @(negedge pins.reset_powerdown_n)
   begin
      err = '0;
      mode = 2'h0;
      ps = 2'h0;
   end
   // read path: id by pin or command, status while busy
   always_comb
   begin
      if ((pins.id_high_voltage && pins.addr[19:1] == 19'h0) || (mode == 2'h2 && !eng))
         rv = {8'h00, pins.addr[0] ? PART_CODE : MAKER_CODE};
      else if (eng || mode == 2'h1)
         rv = {8'h00, !eng, 1'b0, err, 3'b000};
      else
         rv = mem[blk];
   end
   // released lanes show the inverse of their last value, never a stale copy
   assign rd = !pins.ce_n && !pins.oe_n && pins.we_n && pins.reset_powerdown_n;
   always @*
      if (rd) last = rv;
   assign dq[7:0] = rd ? rv[7:0] : ~last[7:0];
   assign dq[15:8] = (rd && pins.wide_n) ? rv[15:8] : ~last[15:8];
endmodule // fcp_flash_model

// ===== bench/fcp_host_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module fcp_host_tb;
   import fcp_pkg::*;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
   localparam logic [7:0] PART = 8'hA4; // arbitrary value
   logic ref_clk;
   logic rst;
   logic vpp_ok;
   fcp_wb_req_t req;
   fcp_wb_rsp_t rsp;
   fcp_pins_t pins;
   logic [15:0] dq;
   logic busy;
   logic [31:0] st;
   logic [31:0] dat;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   fcp_host dut_u (.ref_clk(ref_clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .pins(pins),
      .dq_in(dq), .busy(busy));
   fcp_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (.pins(pins),
      .vpp_ok(vpp_ok), .dq(dq));
   // -----------------------------------------------
   // clock, hang guard and shared tasks
   // -----------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // ceiling far above the roughly 2000 cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // classic cycle: hold until ack is sampled, take data there, then release
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge ref_clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      // only the bench timeout ends this wait
      do
         @(posedge ref_clk);
      while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req <= '0;
   endtask
   // one controller operation, then poll until busy clears
   task automatic run(input logic [2:0] o, input logic [7:0] fl, input logic [19:0] a,
      input logic [15:0] d);
      wb(1'b1, FCP_REG_ADDR, 32'(a), st);
      wb(1'b1, FCP_REG_DATA, 32'(d), st);
      wb(1'b1, FCP_REG_CTRL, {24'h0, fl | 8'(o) | 8'h08}, st);
      @(posedge ref_clk);
      chk("busy", 32'h1, 32'(busy));
      while (o != FCP_OP_READ && pins.we_n !== 1'b0)
         @(posedge ref_clk);
      if (o != FCP_OP_READ) chk("wide_n", 32'(fl[4]), 32'(pins.wide_n));
      do
         wb(1'b0, FCP_REG_STAT, 32'h0, st);
      while (st[8] !== 1'b0);
      wb(1'b0, FCP_REG_DATA, 32'h0, dat);
   endtask
   task automatic rd_chk(input string nm, input logic [19:0] a, input logic [15:0] exp);
      run(FCP_OP_ARRAY, 8'h10, a, 16'h0);
      chk(nm, 32'(exp), dat & 32'hFFFF);
   endtask
   task automatic pd();
      wb(1'b1, FCP_REG_CTRL, 32'h20, st);
      @(posedge ref_clk);
      chk("reset_powerdown_n", 32'h0, 32'(pins.reset_powerdown_n));
      wb(1'b0, FCP_REG_STAT, 32'h0, st);
      chk("powerdown status", 32'h0, st & 32'hFF);
      wb(1'b1, FCP_REG_CTRL, 32'h0, st);
   endtask
   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   task automatic t_prog();
      chk("ce_n", 32'h1, 32'(pins.ce_n));
      wb(1'b0, 4'h2, 32'h0, st);
      chk("unmapped", 32'h0, st);
      run(FCP_OP_READ, 8'h10, 20'h30000, 16'h0);
      chk("array after reset", 32'hFFFF, dat & 32'hFFFF);
      run(FCP_OP_PROG, 8'h10, 20'h30000, 16'hA55A);
      chk("program status", 32'h80, st & 32'hFF);
      run(FCP_OP_PROG, 8'h00, 20'h40000, 16'h1234);
      rd_chk("word programmed", 20'h30000, 16'hA55A);
      rd_chk("byte programmed", 20'h40000, 16'hFF34);
      run(FCP_OP_ERASE, 8'h10, 20'h30000, 16'h0);
      chk("erase status", 32'h80, st & 32'hFF);
      rd_chk("erased block", 20'h30000, 16'hFFFF);
      rd_chk("other block", 20'h40000, 16'hFF34);
      $display("test program erase done");
   endtask
   task automatic t_boot();
      run(FCP_OP_PROG, 8'h10, 20'h00000, 16'h0F0F);
      chk("locked status", 32'h90, st & 32'hFF);
      rd_chk("locked block", 20'h00000, 16'hFFFF);
      pd();
      run(FCP_OP_PROG, 8'h50, 20'h00000, 16'h0F0F);
      chk("unlocked status", 32'h80, st & 32'hFF);
      rd_chk("unlocked block", 20'h00000, 16'h0F0F);
      vpp_ok <= 1'b0;
      run(FCP_OP_ERASE, 8'h10, 20'h50000, 16'h0);
      chk("supply fault status", 32'hA8, st & 32'hFF);
      vpp_ok <= 1'b1;
      pd();
      run(FCP_OP_STATUS, 8'h10, 20'h0, 16'h0);
      chk("status cleared", 32'h80, dat & 32'hFFFF);
      $display("test boot supply done");
   endtask
   task automatic t_ident();
      run(FCP_OP_ID, 8'h10, 20'h00000, 16'h0);
      chk("maker code", 32'(MAKER), dat & 32'hFFFF);
      run(FCP_OP_ID, 8'h10, 20'h00001, 16'h0);
      chk("part code", 32'(PART), dat & 32'hFFFF);
      run(FCP_OP_ARRAY, 8'h90, 20'h00001, 16'h0);
      chk("part code by pin", 32'(PART), dat & 32'hFFFF);
      $display("test identify done");
   endtask
   initial
   begin
      rst = 1'b1;
      vpp_ok = 1'b1;
      req = '0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_prog();
      t_boot();
      t_ident();
      end_sim();
   end
endmodule // fcp_host_tb

// ===== logic/fcp_host.sv
// host controller that drives an asynchronous boot-block flash by its pins
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module fcp_host
   import fcp_pkg::*;
(
   input wire logic ref_clk, // 125 MHz clock
   input wire logic rst, // synchronous reset, high
   input wire fcp_pkg::fcp_wb_req_t wb_req, // wishbone request
   output fcp_pkg::fcp_wb_rsp_t wb_rsp, // wishbone answer
   output fcp_pkg::fcp_pins_t pins, // flash control pins
   input wire logic [15:0] dq_in, // flash data pins as read
   output logic busy // operation in progress
);
   import fcp_pkg::*;

   fcp_regs_t r_r;
   fcp_regs_t r_nxt;
   logic bus_hit;
   logic go;

   // first command byte of an operation
   function automatic logic [7:0] first_cmd(input logic [2:0] op);
      case (op)
         FCP_OP_PROG: first_cmd = FCP_CMD_WRITE_SETUP;
         FCP_OP_ERASE: first_cmd = FCP_CMD_ERASE_SETUP;
         FCP_OP_STATUS: first_cmd = FCP_CMD_READ_STATUS;
         FCP_OP_ID: first_cmd = FCP_CMD_IDENTIFY;
         default: first_cmd = FCP_CMD_READ_ARRAY;
      endcase
   endfunction

   assign bus_hit = wb_req.cyc && wb_req.stb && !r_r.ack;
   assign go = bus_hit && wb_req.we && wb_req.sel[0] && (wb_req.adr == FCP_REG_CTRL)
      && wb_req.dat[FCP_CTRL_GO];

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      r_nxt = r_r;
      r_nxt.ack = bus_hit;
      r_nxt.q1 = dq_in;
      r_nxt.q2 = r_r.q1;
      // register writes; go is refused while busy, ack still given
      if (bus_hit && wb_req.we)
      begin
         case (wb_req.adr)
            FCP_REG_CTRL:
            begin
               r_nxt.wide = wb_req.dat[FCP_CTRL_WIDE];
               r_nxt.rst_pd = wb_req.dat[FCP_CTRL_RESET];
               r_nxt.unlock = wb_req.dat[FCP_CTRL_UNLOCK];
               r_nxt.idv = wb_req.dat[FCP_CTRL_IDV];
               if (go && !r_r.busy)
               begin
                  r_nxt.op = wb_req.dat[FCP_OP_LSB +: FCP_OP_W];
                  r_nxt.busy = 1'b1;
                  r_nxt.st = FCP_CMD1;
                  r_nxt.cnt = FCP_PULSE_CNT;
               end
            end
            FCP_REG_ADDR: r_nxt.addr = wb_req.dat[19:0];
            FCP_REG_DATA: r_nxt.wdata = wb_req.dat[15:0];
            default: ;
         endcase
      end
      // register reads, unmapped reads give zero
      case (wb_req.adr)
         FCP_REG_ADDR: r_nxt.bus_dat = {12'h000, r_r.addr};
         FCP_REG_DATA: r_nxt.bus_dat = {16'h0000, r_r.rdata};
         FCP_REG_STAT: r_nxt.bus_dat = {23'h000000, r_r.busy, r_r.status};
         FCP_REG_CTRL: r_nxt.bus_dat = {24'h000000, r_r.idv, r_r.unlock, r_r.rst_pd,
            r_r.wide, 1'b0, r_r.op};
         default: r_nxt.bus_dat = 32'h00000000;
      endcase
      // strobe pacing counter
      if (r_r.cnt != 5'h00)
         r_nxt.cnt = r_r.cnt - 5'h01;
      // pin defaults
      r_nxt.pins.reset_powerdown_n = !r_r.rst_pd;
      r_nxt.pins.boot_unlock = r_r.unlock;
      r_nxt.pins.id_high_voltage = r_r.idv;
      r_nxt.pins.wide_n = r_r.wide;
      r_nxt.pins.addr = r_r.addr;
      case (r_r.st)
         FCP_IDLE:
         begin
            r_nxt.pins.ce_n = 1'b1;
            r_nxt.pins.oe_n = 1'b1;
            r_nxt.pins.we_n = 1'b1;
            r_nxt.pins.dq_oe = 1'b0;
         end
         // first write: setup or path command on low lanes
         FCP_CMD1:
         begin
            r_nxt.pins.ce_n = 1'b0;
            r_nxt.pins.we_n = 1'b0;
            r_nxt.pins.dq_oe = 1'b1;
            r_nxt.pins.dq_out = {8'h00, first_cmd(r_r.op)};
            if (r_r.cnt == 5'h00)
            begin
               r_nxt.pins.we_n = 1'b1;
               r_nxt.pins.ce_n = 1'b1;
               r_nxt.st = FCP_GAP1;
               r_nxt.cnt = FCP_PULSE_CNT;
            end
         end
         FCP_GAP1:
         begin
            if (r_r.cnt == 5'h00)
            begin
               r_nxt.cnt = FCP_PULSE_CNT;
               if (r_r.op == FCP_OP_PROG || r_r.op == FCP_OP_ERASE)
                  r_nxt.st = FCP_CMD2;
               else if (r_r.op == FCP_OP_READ || r_r.op == FCP_OP_ARRAY)
                  r_nxt.st = FCP_RD;
               else
                  r_nxt.st = FCP_RD;
            end
         end
         // second write: confirm byte or the program data
         FCP_CMD2:
         begin
            r_nxt.pins.ce_n = 1'b0;
            r_nxt.pins.we_n = 1'b0;
            r_nxt.pins.dq_oe = 1'b1;
            if (r_r.op == FCP_OP_ERASE)
               r_nxt.pins.dq_out = {8'h00, FCP_CMD_ERASE_CONFIRM};
            else
               r_nxt.pins.dq_out = r_r.wide ? r_r.wdata : {8'h00, r_r.wdata[7:0]};
            if (r_r.cnt == 5'h00)
            begin
               r_nxt.pins.we_n = 1'b1;
               r_nxt.pins.ce_n = 1'b1;
               r_nxt.st = FCP_GAP2;
               r_nxt.cnt = FCP_PULSE_CNT;
            end
         end
         FCP_GAP2:
         begin
            r_nxt.pins.dq_oe = 1'b0;
            if (r_r.cnt == 5'h00)
            begin
               r_nxt.st = FCP_POLL;
               r_nxt.cnt = FCP_PULSE_CNT;
            end
         end
         // single read with write enable high, selects low
         FCP_RD:
         begin
            r_nxt.pins.dq_oe = 1'b0;
            r_nxt.pins.ce_n = 1'b0;
            r_nxt.pins.oe_n = 1'b0;
            if (r_r.cnt == 5'h00)
            begin
               r_nxt.rdata = r_r.wide ? r_r.q2 : {8'h00, r_r.q2[7:0]};
               if (r_r.op == FCP_OP_STATUS)
                  r_nxt.status = r_r.q2[7:0];
               r_nxt.st = FCP_DONE;
            end
         end
         // poll status until the engine reports ready
         FCP_POLL:
         begin
            r_nxt.pins.ce_n = 1'b0;
            r_nxt.pins.oe_n = 1'b0;
            if (r_r.cnt == 5'h00)
            begin
               r_nxt.status = r_r.q2[7:0];
               r_nxt.pins.oe_n = 1'b1;
               r_nxt.pins.ce_n = 1'b1;
               r_nxt.cnt = FCP_PULSE_CNT;
               if (r_r.q2[FCP_SR_READY])
                  r_nxt.st = FCP_DONE;
            end
         end
         FCP_DONE:
         begin
            r_nxt.pins.ce_n = 1'b1;
            r_nxt.pins.oe_n = 1'b1;
            r_nxt.busy = 1'b0;
            r_nxt.st = FCP_IDLE;
         end
         default: r_nxt.st = FCP_IDLE;
      endcase
      // power-down aborts any operation; device returns to array read
      if (r_r.rst_pd)
      begin
         r_nxt.st = FCP_IDLE;
         r_nxt.busy = 1'b0;
         r_nxt.status = 8'h00;
         r_nxt.pins.dq_oe = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         r_r <= '0;
         r_r.st <= FCP_IDLE;
         r_r.pins.ce_n <= 1'b1;
         r_r.pins.oe_n <= 1'b1;
         r_r.pins.we_n <= 1'b1;
         r_r.pins.reset_powerdown_n <= 1'b1;
      end
      else
         r_r <= r_nxt;
   end

   assign wb_rsp = '{ack: r_r.ack, dat: r_r.bus_dat};
   assign pins = r_r.pins;
   assign busy = r_r.busy;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   read_strobes_a: assert property (@(posedge ref_clk) disable iff (rst)
      !pins.oe_n |-> pins.we_n && !pins.ce_n)
      else $error("read strobe with write enable low");
   cmd_lanes_a: assert property (@(posedge ref_clk) disable iff (rst)
      (r_r.st == FCP_CMD1) |=> (pins.dq_out[15:8] == 8'h00))
      else $error("command on upper lanes");
   // checked only on entry: the confirm strobe spans many cycles in one state
   erase_order_a: assert property (@(posedge ref_clk) disable iff (rst)
      r_r.st == FCP_CMD2 && $past(r_r.st) != FCP_CMD2 && r_r.op == FCP_OP_ERASE |->
      $past(r_r.st) == FCP_GAP1)
      else $error("confirm without setup");
   prog_setup_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(r_r.st == FCP_CMD1) && r_r.op == FCP_OP_PROG ##1 1'b1 |->
      pins.dq_out[7:0] == FCP_CMD_WRITE_SETUP)
      else $error("program without setup byte");
   pd_status_a: assert property (@(posedge ref_clk) disable iff (rst)
      r_r.rst_pd |=> r_r.status == 8'h00 && !pins.dq_oe)
      else $error("power-down did not clear status");
   no_drive_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      !pins.oe_n |-> !pins.dq_oe)
      else $error("driving pins during read");
   unlock_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      r_r.unlock |=> pins.boot_unlock)
      else $error("unlock pin not following");
   width_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      r_r.wide ##1 r_r.wide |-> pins.wide_n)
      else $error("width pin mismatch");
   ack_once_a: assert property (@(posedge ref_clk) disable iff (rst)
      wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack held two cycles");
   cv_erase_c: cover property (@(posedge ref_clk) r_r.st == FCP_CMD2 && r_r.op == FCP_OP_ERASE);
   cv_prog_c: cover property (@(posedge ref_clk) r_r.st == FCP_CMD2 && r_r.op == FCP_OP_PROG);
   cv_poll_c: cover property (@(posedge ref_clk) r_r.st == FCP_POLL ##1 r_r.st == FCP_DONE);
   cv_id_c: cover property (@(posedge ref_clk) r_r.st == FCP_RD && r_r.op == FCP_OP_ID);
endmodule // fcp_host

// ===== shared/fcp_pkg.sv
// package for the flash command host controller
package fcp_pkg;
   // command bytes placed on the low data lanes
   localparam logic [7:0] FCP_CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] FCP_CMD_ERASE_CONFIRM = 8'hD0;
   localparam logic [7:0] FCP_CMD_WRITE_SETUP = 8'h40;
   localparam logic [7:0] FCP_CMD_WRITE_SETUP_ALT = 8'h10;
   localparam logic [7:0] FCP_CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] FCP_CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] FCP_CMD_IDENTIFY = 8'h90;
   // status bit positions on the low lanes
   localparam int FCP_SR_READY = 7;
   localparam int FCP_SR_ESUSP = 6;
   localparam int FCP_SR_ERASE_ERR = 5;
   localparam int FCP_SR_PROG_ERR = 4;
   localparam int FCP_SR_SUPPLY_ERR = 3;
   // host register offsets (wishbone byte addresses)
   localparam logic [3:0] FCP_REG_CTRL = 4'h0;
   localparam logic [3:0] FCP_REG_ADDR = 4'h4;
   localparam logic [3:0] FCP_REG_DATA = 4'h8;
   localparam logic [3:0] FCP_REG_STAT = 4'hC;
   // ctrl register fields
   localparam int FCP_OP_LSB = 0;
   localparam int FCP_OP_W = 3;
   localparam int FCP_CTRL_GO = 3;
   localparam int FCP_CTRL_WIDE = 4;
   localparam int FCP_CTRL_RESET = 5;
   localparam int FCP_CTRL_UNLOCK = 6;
   localparam int FCP_CTRL_IDV = 7;
   // operation codes
   localparam logic [2:0] FCP_OP_READ = 3'h0;
   localparam logic [2:0] FCP_OP_PROG = 3'h1;
   localparam logic [2:0] FCP_OP_ERASE = 3'h2;
   localparam logic [2:0] FCP_OP_STATUS = 3'h3;
   localparam logic [2:0] FCP_OP_ID = 3'h4;
   localparam logic [2:0] FCP_OP_ARRAY = 3'h5;
   // pin strobe timing
   localparam int FCP_CLK_MHZ = 125;
   localparam int FCP_T_PULSE_NS = 100;
   localparam int FCP_PULSE_CYC = (FCP_T_PULSE_NS * FCP_CLK_MHZ + 999) / 1000;
   localparam logic [4:0] FCP_PULSE_CNT = 5'(FCP_PULSE_CYC);

   typedef enum logic [7:0]
   {
      FCP_IDLE = 8'h01,
      FCP_CMD1 = 8'h02,
      FCP_GAP1 = 8'h04,
      FCP_CMD2 = 8'h08,
      FCP_GAP2 = 8'h10,
      FCP_RD = 8'h20,
      FCP_POLL = 8'h40,
      FCP_DONE = 8'h80
   } fcp_state_t;

   // wishbone slave request and answer
   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } fcp_wb_req_t;
   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
   } fcp_wb_rsp_t;

   // flash pin group driven by the controller
   typedef struct packed
   {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_powerdown_n;
      logic boot_unlock;
      logic wide_n;
      logic id_high_voltage;
      logic [19:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } fcp_pins_t;

   // whole controller state
   typedef struct packed
   {
      fcp_state_t st;
      logic [4:0] cnt;
      logic [2:0] op;
      logic wide;
      logic rst_pd;
      logic unlock;
      logic idv;
      logic busy;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [7:0] status;
      logic [15:0] q1;
      logic [15:0] q2;
      logic ack;
      logic [31:0] bus_dat;
      fcp_pins_t pins;
   } fcp_regs_t;
endpackage
